/* File: stats_pkg.sv */
// Shared register map, field positions and reset values of the statistics bank
package stats_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_TX_CTRL      = 12'h845;
    localparam logic [11:0] IDX_TX_STATUS    = 12'h846;
    localparam logic [11:0] IDX_INT_STATUS   = 12'h848;
    localparam logic [11:0] IDX_INT_MASK     = 12'h849;
    localparam logic [11:0] IDX_RX_MAX_SIZE  = 12'h84A;
    localparam logic [11:0] IDX_WORD_A       = 12'h84B;
    localparam logic [11:0] IDX_TX_PAY_LO    = 12'h860;
    localparam logic [11:0] IDX_TX_PAY_HI    = 12'h861;
    localparam logic [11:0] IDX_TX_FRM_LO    = 12'h862;
    localparam logic [11:0] IDX_TX_FRM_HI    = 12'h863;
    localparam logic [11:0] IDX_RX_RUNT_LO   = 12'h900;
    localparam logic [11:0] IDX_RX_RUNT_HI   = 12'h901;
    localparam logic [11:0] IDX_RX_LONG_LO   = 12'h902;
    localparam logic [11:0] IDX_RX_LONG_HI   = 12'h903;
    localparam logic [11:0] IDX_RX_CHECK_LO  = 12'h904;
    localparam logic [11:0] IDX_RX_CHECK_HI  = 12'h905;

    // Address slice that carries the word index
    localparam int          IDX_LSB          = 2;
    localparam int          IDX_MSB          = 13;

    // tx_counter_control fields
    localparam int          CTRL_CLR_ALL     = 0;
    localparam int          CTRL_PAR_CLR     = 1;
    localparam int          CTRL_SHADOW      = 2;
    // tx_counter_status fields
    localparam int          STAT_PAR_ERR     = 0;
    localparam int          STAT_PAUSED      = 1;
    // word_a field that turns transmit VLAN detection off
    localparam int          WORDA_VLAN_OFF   = 1;

    // Interrupt status and mask bits
    localparam int          INT_W            = 4;
    localparam int          INT_PARITY       = 0;
    localparam int          INT_RUNT         = 1;
    localparam int          INT_LONG         = 2;
    localparam int          INT_CHECK        = 3;

    // Frame figures
    localparam logic [15:0] RUNT_LIMIT       = 16'h0040;
    localparam logic [15:0] VLAN_ONE_BYTES   = 16'h0004;
    localparam logic [15:0] VLAN_TWO_BYTES   = 16'h0008;
    localparam logic [1:0]  VLAN_NONE        = 2'h0;
    localparam logic [1:0]  VLAN_SINGLE      = 2'h1;
    localparam logic [1:0]  VLAN_STACKED     = 2'h2;

    // Reset values
    localparam logic [15:0] RX_MAX_RST       = 16'h05EE;
    localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
    localparam logic [31:0] WORD_A_RST       = 32'h0000_0000;

endpackage

/* File: stat_counter64.sv */
// One 64-bit statistics counter with a stored parity bit
`timescale 1ns/1ps
module stat_counter64
    import stats_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        clr,
    input  wire logic        inc_en,
    input  wire logic [15:0] inc_val,
    // State
    output logic      [63:0] value,
    output logic             par_err
);

    typedef struct packed {
        logic [63:0] cnt;
        logic        par;
    } cnt_state_t;

    cnt_state_t st_q;
    cnt_state_t st_d;

    always_comb begin
        st_d = st_q;
        // A bulk clear beats an increment arriving in the same cycle
        if (clr) begin
            st_d.cnt = 64'h0;
            st_d.par = 1'b0;
        end else if (inc_en) begin
            st_d.cnt = st_q.cnt + {48'h0, inc_val};
            st_d.par = ^st_d.cnt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign value   = st_q.cnt;
    // Stored parity against the word catches an upset in the counter bits
    assign par_err = (^st_q.cnt) ^ st_q.par;

    a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        inc_en && !clr |=> value == $past(value) + {48'h0, $past(inc_val)})
        else $error("counter did not advance by the increment");

endmodule // stat_counter64

/* File: ahb_front.sv */
// AHB-Lite slave front end: address phase capture and zero-wait answer
`timescale 1ns/1ps
module ahb_front
    import stats_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite address phase
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    // AHB-Lite answer
    output logic             hreadyout,
    output logic             hresp,
    // Register side
    output logic             rd_req,
    output logic [11:0]      rd_idx,
    output logic             wr_req,
    output logic [11:0]      wr_idx
);

    typedef struct packed {
        logic        wr;
        logic [11:0] idx;
    } front_state_t;

    front_state_t st_q;
    front_state_t st_d;
    logic         take;

    // NONSEQ or SEQ both count as a transfer
    assign take = hsel && htrans[1] && hready;

    always_comb begin
        st_d     = st_q;
        st_d.wr  = take && hwrite;
        st_d.idx = take ? haddr[IDX_MSB:IDX_LSB] : st_q.idx;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_req    = take && !hwrite;
    assign rd_idx    = haddr[IDX_MSB:IDX_LSB];
    assign wr_req    = st_q.wr;
    assign wr_idx    = st_q.idx;
    // Every access finishes with no wait and an OKAY response
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule // ahb_front

/* File: eth_stats_counters.sv */
// Ethernet statistics counter bank with transmit freeze and AHB-Lite access
//
// Functional notes
// - While the shadow bit is set, transmit counter reads show a frozen copy.
// - Status bit 1 reads high for as long as the shadow bit is set.
// - Writing one to control bit 1 clears the parity status; it self-clears.
// - Writing one to control bit 0 zeroes all transmit counters; it self-clears.
// - Status bit 0 sets on any transmit counter parity error and holds.
// - Control bits 31:3 and status bits 31:2 do nothing and read as zero.
// - Payload bytes add up only for frames with no length or check errors.
// - With VLAN detection off, payload counts add four or eight tag bytes.
// - Frame bytes add up only for frames with no length or check errors.
// - A received frame under 64 bytes with a CRC error counts as a runt.
// - A received oversized frame with a CRC error counts as a long frame.
// - The check error counter steps once for each cycle the check error input is high.
// - Each counter is 64 bits, read as low then high word at adjacent slots.
// - A received frame is oversized when longer than the programmed maximum.
`timescale 1ns/1ps
module eth_stats_counters
    import stats_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Transmit frame events
    input  wire logic        tx_frame_done,
    input  wire logic [15:0] tx_frame_len,
    input  wire logic [15:0] tx_payload_len,
    input  wire logic [1:0]  tx_vlan_tags,
    input  wire logic        tx_fcs_err,
    input  wire logic        tx_undersize,
    input  wire logic        tx_oversize,
    input  wire logic        tx_len_err,
    // Receive frame events
    input  wire logic        rx_frame_done,
    input  wire logic [15:0] rx_frame_len,
    input  wire logic        rx_crc_err,
    input  wire logic        rx_fcs_error,
    // Interrupt
    output logic             irq
);

    typedef struct packed {
        logic              shadow;
        logic [63:0]       snap_pay;
        logic [63:0]       snap_frm;
        logic              par_sticky;
        logic [INT_W-1:0]  int_stat;
        logic [INT_W-1:0]  int_mask;
        logic [15:0]       rx_max;
        logic [31:0]       word_a;
        logic [31:0]       rdata;
    } bank_state_t;

    bank_state_t st_q;
    bank_state_t st_d;

    logic        rd_req;
    logic [11:0] rd_idx;
    logic        wr_req;
    logic [11:0] wr_idx;

    logic        wr_ctrl;
    logic        clr_all;
    logic        par_clr;
    logic        tx_good;
    logic        vlan_off;
    logic [15:0] vlan_extra;
    logic [15:0] pay_inc;
    logic        rx_runt;
    logic        rx_long;

    logic [63:0] live_pay;
    logic [63:0] live_frm;
    logic [63:0] cnt_runt;
    logic [63:0] cnt_long;
    logic [63:0] cnt_check;
    logic        perr_pay;
    logic        perr_frm;
    logic        perr_runt;
    logic        perr_long;
    logic        perr_check;
    logic        tx_perr;
    logic [63:0] rd_pay;
    logic [63:0] rd_frm;
    logic [INT_W-1:0] int_evt;

    ahb_front u_front (
        .clk       (clk),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rd_req    (rd_req),
        .rd_idx    (rd_idx),
        .wr_req    (wr_req),
        .wr_idx    (wr_idx)
    );

    // Only word accesses are defined; narrower sizes are handled as words
    assign wr_ctrl  = wr_req && (wr_idx == IDX_TX_CTRL);
    assign clr_all  = wr_ctrl && hwdata[CTRL_CLR_ALL];
    assign par_clr  = wr_ctrl && hwdata[CTRL_PAR_CLR];

    assign tx_good  = tx_frame_done && !tx_fcs_err && !tx_undersize
                      && !tx_oversize && !tx_len_err;
    assign vlan_off = st_q.word_a[WORDA_VLAN_OFF];

    always_comb begin
        vlan_extra = 16'h0;
        if (vlan_off) begin
            case (tx_vlan_tags)
                VLAN_SINGLE:  vlan_extra = VLAN_ONE_BYTES;
                VLAN_STACKED: vlan_extra = VLAN_TWO_BYTES;
                default:      vlan_extra = 16'h0;
            endcase
        end
    end
    assign pay_inc  = tx_payload_len + vlan_extra;

    assign rx_runt  = rx_frame_done && rx_crc_err
                      && (rx_frame_len < RUNT_LIMIT);
    assign rx_long  = rx_frame_done && rx_crc_err
                      && (rx_frame_len > st_q.rx_max);

    stat_counter64 u_tx_pay (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (clr_all),
        .inc_en  (tx_good),
        .inc_val (pay_inc),
        .value   (live_pay),
        .par_err (perr_pay)
    );

    stat_counter64 u_tx_frm (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (clr_all),
        .inc_en  (tx_good),
        .inc_val (tx_frame_len),
        .value   (live_frm),
        .par_err (perr_frm)
    );

    stat_counter64 u_rx_runt (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (1'b0),
        .inc_en  (rx_runt),
        .inc_val (16'h0001),
        .value   (cnt_runt),
        .par_err (perr_runt)
    );

    stat_counter64 u_rx_long (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (1'b0),
        .inc_en  (rx_long),
        .inc_val (16'h0001),
        .value   (cnt_long),
        .par_err (perr_long)
    );

    stat_counter64 u_rx_check (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (1'b0),
        .inc_en  (rx_fcs_error),
        .inc_val (16'h0001),
        .value   (cnt_check),
        .par_err (perr_check)
    );

    // Receive counter parity is not part of the transmit status word
    assign tx_perr = perr_pay || perr_frm;

    // The frozen copy is only shown, the live counters keep running
    assign rd_pay  = st_q.shadow ? st_q.snap_pay : live_pay;
    assign rd_frm  = st_q.shadow ? st_q.snap_frm : live_frm;

    assign int_evt = {rx_fcs_error, rx_long, rx_runt, tx_perr};

    always_comb begin
        st_d = st_q;

        // Freeze: both halves of every transmit counter copied together
        if (wr_ctrl) begin
            st_d.shadow = hwdata[CTRL_SHADOW];
            if (hwdata[CTRL_SHADOW] && !st_q.shadow) begin
                st_d.snap_pay = live_pay;
                st_d.snap_frm = live_frm;
            end
        end

        // Set wins over a clear in the same cycle
        if (tx_perr) begin
            st_d.par_sticky = 1'b1;
        end else if (par_clr) begin
            st_d.par_sticky = 1'b0;
        end

        if (wr_req && wr_idx == IDX_INT_STATUS) begin
            st_d.int_stat = st_q.int_stat & ~hwdata[INT_W-1:0];
        end
        st_d.int_stat = st_d.int_stat | int_evt;

        if (wr_req && wr_idx == IDX_INT_MASK) begin
            st_d.int_mask = hwdata[INT_W-1:0];
        end
        if (wr_req && wr_idx == IDX_RX_MAX_SIZE) begin
            st_d.rx_max = hwdata[15:0];
        end
        if (wr_req && wr_idx == IDX_WORD_A) begin
            st_d.word_a = hwdata;
        end

        // Read data is fetched in the address phase so it stands registered
        // through the data phase; unmapped slots read as zero
        if (rd_req) begin
            case (rd_idx)
                IDX_TX_CTRL:     st_d.rdata = {29'h0, st_q.shadow, 2'h0};
                IDX_TX_STATUS:   st_d.rdata = {30'h0, st_q.shadow,
                                               st_q.par_sticky};
                IDX_INT_STATUS:  st_d.rdata = {28'h0, st_q.int_stat};
                IDX_INT_MASK:    st_d.rdata = {28'h0, st_q.int_mask};
                IDX_RX_MAX_SIZE: st_d.rdata = {16'h0, st_q.rx_max};
                IDX_WORD_A:      st_d.rdata = st_q.word_a;
                IDX_TX_PAY_LO:   st_d.rdata = rd_pay[31:0];
                IDX_TX_PAY_HI:   st_d.rdata = rd_pay[63:32];
                IDX_TX_FRM_LO:   st_d.rdata = rd_frm[31:0];
                IDX_TX_FRM_HI:   st_d.rdata = rd_frm[63:32];
                IDX_RX_RUNT_LO:  st_d.rdata = cnt_runt[31:0];
                IDX_RX_RUNT_HI:  st_d.rdata = cnt_runt[63:32];
                IDX_RX_LONG_LO:  st_d.rdata = cnt_long[31:0];
                IDX_RX_LONG_HI:  st_d.rdata = cnt_long[63:32];
                IDX_RX_CHECK_LO: st_d.rdata = cnt_check[31:0];
                IDX_RX_CHECK_HI: st_d.rdata = cnt_check[63:32];
                default:         st_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q          <= '0;
            st_q.int_mask <= INT_MASK_RST;
            st_q.rx_max   <= RX_MAX_RST;
            st_q.word_a   <= WORD_A_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign hrdata = st_q.rdata;
    assign irq    = |(st_q.int_stat & st_q.int_mask);

    // Checks

    sequence s_good_tx;
        tx_good && !clr_all;
    endsequence

    sequence s_freeze_start;
        wr_ctrl && hwdata[CTRL_SHADOW] && !st_q.shadow;
    endsequence

    sequence s_status_read;
        rd_req && rd_idx == IDX_TX_STATUS;
    endsequence

    property p_snap_taken;
        @(posedge clk) disable iff (!rst_n)
        s_freeze_start |=> st_q.shadow
            && st_q.snap_pay == $past(live_pay)
            && st_q.snap_frm == $past(live_frm);
    endproperty

    a_snapshot_pair: assert property (p_snap_taken)
        else $error("snapshot halves not taken together");

    a_freeze_stable: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.shadow ##1 st_q.shadow
        |-> $stable(rd_pay) && $stable(rd_frm))
        else $error("frozen transmit values moved");

    a_paused_flag: assert property (@(posedge clk) disable iff (!rst_n)
        s_status_read |=> hrdata[STAT_PAUSED] == $past(st_q.shadow)
            && hrdata[31:2] == 30'h0)
        else $error("paused flag does not follow shadow bit");

    a_parity_clear: assert property (@(posedge clk) disable iff (!rst_n)
        par_clr && !tx_perr |=> !st_q.par_sticky)
        else $error("parity status not cleared");

    a_bulk_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clr_all |=> live_pay == 64'h0 && live_frm == 64'h0)
        else $error("transmit counters not cleared");

    a_parity_hold: assert property (@(posedge clk) disable iff (!rst_n)
        tx_perr || (st_q.par_sticky && !par_clr)
        |=> st_q.par_sticky)
        else $error("parity status lost");

    a_bad_tx_skip: assert property (@(posedge clk) disable iff (!rst_n)
        tx_frame_done && !tx_good && !clr_all |=> $stable(live_pay)
            && $stable(live_frm))
        else $error("errored frame counted");

    a_vlan_bytes: assert property (@(posedge clk) disable iff (!rst_n)
        s_good_tx and (vlan_off && tx_vlan_tags == VLAN_STACKED)
        |=> live_pay == $past(live_pay)
            + {48'h0, $past(tx_payload_len)} + 64'h8)
        else $error("stacked tag bytes not added");

    a_frame_bytes: assert property (@(posedge clk) disable iff (!rst_n)
        s_good_tx |=> live_frm == $past(live_frm)
            + {48'h0, $past(tx_frame_len)})
        else $error("frame bytes not added");

    a_runt_count: assert property (@(posedge clk) disable iff (!rst_n)
        rx_frame_done && rx_crc_err && rx_frame_len < RUNT_LIMIT
        |=> cnt_runt == $past(cnt_runt) + 64'h1)
        else $error("runt not counted");

    a_long_count: assert property (@(posedge clk) disable iff (!rst_n)
        rx_frame_done && rx_crc_err && rx_frame_len > st_q.rx_max
        |=> cnt_long == $past(cnt_long) + 64'h1)
        else $error("long frame not counted");

    a_check_count: assert property (@(posedge clk) disable iff (!rst_n)
        rx_fcs_error |=> cnt_check == $past(cnt_check) + 64'h1)
        else $error("check error pulse not counted");

    a_high_word: assert property (@(posedge clk) disable iff (!rst_n)
        rd_req && rd_idx == IDX_RX_CHECK_HI
        |=> hrdata == $past(cnt_check[63:32]))
        else $error("high word read wrong");

endmodule // eth_stats_counters

/* File: mac_event_src.sv */
// MAC transmit and receive event source feeding the statistics bank
`timescale 1ns/1ps
module mac_event_src (
    // Clock
    input  wire logic        clk,
    // Transmit frame events
    output logic             tx_frame_done,
    output logic      [15:0] tx_frame_len,
    output logic      [15:0] tx_payload_len,
    output logic      [1:0]  tx_vlan_tags,
    output logic      [3:0]  tx_errs,
    // Receive frame events
    output logic             rx_frame_done,
    output logic      [15:0] rx_frame_len,
    output logic             rx_crc_err,
    output logic             rx_fcs_error
);
    initial begin
        tx_frame_done = 1'b0;
        tx_frame_len = 16'h0;
        tx_payload_len = 16'h0;
        tx_vlan_tags = 2'h0;
        tx_errs = 4'h0;
        rx_frame_done = 1'b0;
        rx_frame_len = 16'h0;
        rx_crc_err = 1'b0;
        rx_fcs_error = 1'b0;
    end

    // Qualifiers mean nothing outside the pulse, so they are scrambled
    task automatic send_tx(input logic [15:0] fl, pl, input logic [1:0] vt,
                           input logic [3:0] er);
        @(posedge clk);
        tx_frame_done <= 1'b1;
        tx_frame_len <= fl;
        tx_payload_len <= pl;
        tx_vlan_tags <= vt;
        tx_errs <= er;
        @(posedge clk);
        tx_frame_done <= 1'b0;
        tx_frame_len <= ~fl;
        tx_payload_len <= ~pl;
        tx_vlan_tags <= ~vt;
        tx_errs <= ~er;
    endtask

    task automatic send_rx(input logic [15:0] fl, input logic crc);
        @(posedge clk);
        rx_frame_done <= 1'b1;
        rx_frame_len <= fl;
        rx_crc_err <= crc;
        @(posedge clk);
        rx_frame_done <= 1'b0;
        rx_frame_len <= ~fl;
        rx_crc_err <= ~crc;
    endtask

    task automatic pulse_fcs(input int n);
        @(posedge clk);
        rx_fcs_error <= 1'b1;
        repeat (n) @(posedge clk);
        rx_fcs_error <= 1'b0;
    endtask
endmodule // mac_event_src

/* File: test_ethernet_stats_counters.sv */
// Self-checking bench of the Ethernet statistics bank
`timescale 1ns/1ps
module test_ethernet_stats_counters;
    import stats_pkg::*;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            hsel = 1'b0;
    logic [31:0]     haddr = 32'h0;
    logic [1:0]      htrans = 2'h0;
    logic            hwrite = 1'b0;
    logic [31:0]     hwdata = 32'h0;
    logic            hready, hresp, irq, txd, rxd, rxc, fcs;
    logic [31:0]     hrdata, rd;
    logic [15:0]     tfl, tpl, rfl;
    logic [1:0]      tvt;
    logic [3:0]      ter;
    logic [31:0]     r = 32'h28FD;
    logic [3:0]      ist = 4'h0;
    logic [3:0]      msk = 4'h0;
    int              n_fail = 0;
    int              checks = 0;
    int              cyc = 0;
    int              len, pl;
    bit              shadow = 0;
    bit              voff = 0;
    longint unsigned pay = 0, frm = 0, pay_s = 0, frm_s = 0;
    longint unsigned runt = 0, lng = 0, fce = 0;

    always #25 clk = ~clk;

    eth_stats_counters uut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .tx_frame_done(txd), .tx_frame_len(tfl), .tx_payload_len(tpl),
        .tx_vlan_tags(tvt), .tx_fcs_err(ter[0]), .tx_undersize(ter[1]),
        .tx_oversize(ter[2]), .tx_len_err(ter[3]), .rx_frame_done(rxd),
        .rx_frame_len(rfl), .rx_crc_err(rxc), .rx_fcs_error(fcs), .irq(irq));

    mac_event_src src (
        .clk(clk), .tx_frame_done(txd), .tx_frame_len(tfl),
        .tx_payload_len(tpl), .tx_vlan_tags(tvt), .tx_errs(ter),
        .rx_frame_done(rxd), .rx_frame_len(rfl), .rx_crc_err(rxc),
        .rx_fcs_error(fcs));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic [11:0] ix, input logic wr,
                       input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {18'h0, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic rdc(input string nm, input logic [11:0] ix,
                       input logic [31:0] e);
        bus(ix, 1'b0, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic chk64(input string nm, input logic [11:0] ix,
                         input longint unsigned v);
        rdc(nm, ix, v[31:0]);
        rdc(nm, ix + 12'h1, v[63:32]);
    endtask

    task automatic chk_tx;
        chk64("tx_payload", IDX_TX_PAY_LO, shadow ? pay_s : pay);
        chk64("tx_frame", IDX_TX_FRM_LO, shadow ? frm_s : frm);
    endtask

    task automatic chk_irq;
        @(negedge clk);
        chk("irq", {31'h0, |(ist & msk)}, {31'h0, irq});
    endtask

    task automatic tx_rand;
        logic [3:0] er;
        r = lfsr(r);
        er = r[20] ? r[19:16] : 4'h0;
        len = 64 + int'(r[10:0]);
        pl = int'(r[26:21]);
        src.send_tx(len[15:0], pl[15:0], r[31:30], er);
        if (er == 4'h0) begin
            frm += len;
            pay += pl;
            if (voff && r[31:30] == VLAN_SINGLE) pay += 4;
            if (voff && r[31:30] == VLAN_STACKED) pay += 8;
        end
    endtask

    task automatic rx_frame(input int l, input logic crc);
        src.send_rx(l[15:0], crc);
        if (crc && l < 64) begin
            runt++;
            ist[INT_RUNT] = 1'b1;
        end
        if (crc && l > 100) begin
            lng++;
            ist[INT_LONG] = 1'b1;
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc("status", IDX_TX_STATUS, 32'h0);
        rdc("mask", IDX_INT_MASK, 32'h0);
        rdc("rx_max", IDX_RX_MAX_SIZE, 32'h5EE);
        rdc("unmapped", 12'h850, 32'h0);
        bus(IDX_TX_PAY_LO, 1'b1, 32'hFFFF);
        chk_tx;
        bus(IDX_RX_MAX_SIZE, 1'b1, 32'h64);
        for (int v = 0; v < 2; v++) begin
            voff = v[0];
            bus(IDX_WORD_A, 1'b1, {30'h0, voff, 1'b0});
            repeat (20) tx_rand;
            chk_tx;
        end
        rx_frame(63, 1'b1);
        rx_frame(64, 1'b1);
        rx_frame(101, 1'b1);
        rx_frame(100, 1'b1);
        for (int i = 0; i < 30; i++) begin
            r = lfsr(r);
            rx_frame(int'(r[7:0]), r[8]);
        end
        src.pulse_fcs(3);
        fce += 3;
        ist[INT_CHECK] = 1'b1;
        chk64("rx_runt", IDX_RX_RUNT_LO, runt);
        chk64("rx_long", IDX_RX_LONG_LO, lng);
        chk64("rx_check", IDX_RX_CHECK_LO, fce);
        // Reserved bits set alongside the freeze request
        bus(IDX_TX_CTRL, 1'b1, 32'hFFFF_FFFC);
        shadow = 1;
        pay_s = pay;
        frm_s = frm;
        rdc("ctrl", IDX_TX_CTRL, 32'h4);
        rdc("status", IDX_TX_STATUS, 32'h2);
        repeat (10) tx_rand;
        chk_tx;
        bus(IDX_TX_CTRL, 1'b1, 32'h7);
        pay = 0;
        frm = 0;
        rdc("ctrl", IDX_TX_CTRL, 32'h4);
        chk_tx;
        repeat (3) tx_rand;
        bus(IDX_TX_CTRL, 1'b1, 32'h0);
        shadow = 0;
        rdc("status", IDX_TX_STATUS, 32'h0);
        chk_tx;
        chk_irq;
        bus(IDX_INT_MASK, 1'b1, 32'hA);
        msk = 4'hA;
        rdc("int_status", IDX_INT_STATUS, {28'h0, ist});
        chk_irq;
        bus(IDX_INT_STATUS, 1'b1, 32'hF);
        ist = 4'h0;
        rdc("int_status", IDX_INT_STATUS, 32'h0);
        chk_irq;
        print_verdict;
    end
endmodule // test_ethernet_stats_counters
